/* include/diag_status_regs.vh */
// Constants for the safety diagnosis status bank: register indices,
// fault bit positions, word reset value and width of the reset-request pulse.
// Assumes inclusion by bare name from design files under hw/.
`ifndef DIAG_STATUS_REGS_VH
`define DIAG_STATUS_REGS_VH

// Register indices on the programming interface address
`define REG_PROCESSING_FAULT 4'h0
`define REG_SUPPLY_FAULT     4'h1

// Processing fault word bit positions
`define PF_DSP_SELFCHECK  15
`define PF_NVM_CHECKSUM   14
`define PF_MEM_CHECKSUM   13
`define PF_TEMP_RANGE     12
`define PF_TEMP_REDUND    11
`define PF_HALL_SUPPLY    10
`define PF_OVERTEMP       9
`define PF_ADC_STUCK      7
`define PF_DECIM_FLOW     6
`define PF_MAG_HIGH       5
`define PF_MAG_LOW        4
`define PF_POS_HIGH       3
`define PF_POS_LOW        2
`define PF_HALL_CURRENT   1

// Supply fault word bit positions
`define SF_GP_ADC_A       14
`define SF_GP_ADC_B       12
`define SF_UNDERVOLT      11
`define SF_OVERVOLT       10
`define SF_ANALOG_V       9
`define SF_DIGITAL_V      8

// Reset values of both words
`define FAULT_WORD_RESET  16'h0000

// Width of the reset-request pulse in clock cycles
`define RESET_PULSE_CYCLES 4'h4

`endif

/* hw/fault_sync.v */
// Three-stage synchroniser with agreement filter for a bundle of fault inputs.
// Assumes inputs come from outside the clk_sys domain.
`timescale 1ns/1ps
module fault_sync #(
  parameter WIDTH = 8                    // Number of fault lines
) (
  input  wire             clk_sys,       // System clock
  input  wire             reset_n,       // Asynchronous active-low reset
  input  wire [WIDTH-1:0] raw,           // Unsynchronised fault levels
  output reg  [WIDTH-1:0] clean          // Filtered, synchronised levels
);

  reg [WIDTH-1:0] stage1;                // First flop, read only by stage2
  reg [WIDTH-1:0] stage2;                // Second flop
  reg [WIDTH-1:0] stage3;                // Third flop

  // Shift chain; a line changes once stage2 and stage3 agree
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      clean  <= {WIDTH{1'b0}};
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
      // Update only bits where the last two stages agree
      clean  <= (clean & ~(stage2 ~^ stage3)) | (stage2 & (stage2 ~^ stage3));
    end
  end

endmodule

/* hw/safety_diagnosis_status_bank.v */
// Safety diagnosis status bank: collects self-test fault levels into two
// 16-bit read-only status words, flags faults to the output framer and
// requests a device reset for the critical supply faults.
// Assumes fault detectors drive levels from other domains, and the
// programming interface issues single-cycle reads with an index.
`timescale 1ns/1ps
`include "diag_status_regs.vh"

module safety_diagnosis_status_bank #(
  parameter CRIT_WIDTH = 8                      // Critical supply fault lines
) (
  input  wire                  clk_sys,         // System clock, 50 MHz
  input  wire                  reset_n,         // Asynchronous active-low reset
  input  wire                  dsp_selfcheck_fail,
  input  wire                  nvm_checksum_fail,
  input  wire                  mem_checksum_fail,
  input  wire                  temp_out_of_range,
  input  wire                  temp_redund_fail,
  input  wire                  hall_supply_high,
  input  wire                  overtemp_hw,
  input  wire [2:0]            adc_stuck,       // One line per channel converter
  input  wire                  decim_overflow,
  input  wire                  decim_underflow,
  input  wire                  mag_above_high,
  input  wire                  mag_below_low,
  input  wire                  pos_above_high,
  input  wire                  pos_below_low,
  input  wire                  hall_current_bad,
  input  wire                  gp_adc_error,
  input  wire                  supply_under,
  input  wire                  supply_over,
  input  wire                  analog_v_bad,
  input  wire                  digital_v_bad,
  input  wire [CRIT_WIDTH-1:0] crit_fault,      // Faults that reset the device
  input  wire                  rd_en,           // Read strobe from programming interface
  input  wire                  wr_en,           // Write strobe, ignored
  input  wire [3:0]            rd_index,        // Register index
  input  wire [15:0]           wr_data,         // Write data, ignored
  output reg  [15:0]           rd_data,         // Read data
  output reg                   rd_valid,        // Read answer strobe
  output reg                   fault_present,   // Any ordinary fault, toward output framer
  output reg                   output_suppress, // Hold output on severe fault
  output reg                   device_reset_req // Reset request pulse
);

  // Count of ordinary fault lines carried in the bundle
  localparam NFLT     = 22;                     // Ordinary fault levels

  // Position of each ordinary fault level inside the bundle.
  // The order matches the concatenation that builds raw_bundle,
  // so a line moved there must be moved here as well.
  localparam B_DSP    = 21;                     // Signal processor self-check
  localparam B_NVM    = 20;                     // Parameter store checksum
  localparam B_MEM    = 19;                     // Program and data memory checksum
  localparam B_TRNG   = 18;                     // Junction temperature range
  localparam B_TRED   = 17;                     // Redundant temperature sensor
  localparam B_HSUP   = 16;                     // Hall-plate supply too high
  localparam B_OTMP   = 15;                     // Hardware overtemperature
  localparam B_ADC_HI = 14;                     // Channel converter stuck, top line
  localparam B_ADC_LO = 12;                     // Channel converter stuck, bottom line
  localparam B_DOF    = 11;                     // Decimation filter overflow
  localparam B_DUF    = 10;                     // Decimation filter underflow
  localparam B_MHI    = 9;                      // Field above upper limit
  localparam B_MLO    = 8;                      // Field below lower limit
  localparam B_PHI    = 7;                      // Position above valid range
  localparam B_PLO    = 6;                      // Position below valid range
  localparam B_HCUR   = 5;                      // Hall-plate current out of range
  localparam B_GPADC  = 4;                      // General converter error
  localparam B_UV     = 3;                      // Supply undervoltage
  localparam B_OV     = 2;                      // Supply overvoltage
  localparam B_AV     = 1;                      // Internal analog voltage
  localparam B_DV     = 0;                      // Internal digital voltage

  wire [NFLT-1:0]       raw_bundle;             // All ordinary fault levels, unsynchronised
  wire [NFLT-1:0]       sync_bundle;            // Ordinary fault levels after filtering
  wire [CRIT_WIDTH-1:0] crit_sync;              // Synchronised critical faults
  reg  [15:0]           processing_fault_status; // First status word
  reg  [15:0]           supply_fault_status;    // Second status word (high byte)
  reg  [15:0]           next_processing;        // Next value of first word
  reg  [15:0]           next_supply;            // Next value of second word
  reg  [3:0]            reset_count;            // Reset pulse stretcher
  wire                  wr_unused;              // Writes have no target

  // Gather the ordinary fault levels into one bundle.
  // Each detector runs in its own domain, so nothing here is
  // trusted before it has passed the synchroniser below.
  assign raw_bundle = {dsp_selfcheck_fail, nvm_checksum_fail, mem_checksum_fail,
                       temp_out_of_range, temp_redund_fail, hall_supply_high, overtemp_hw,
                       adc_stuck, decim_overflow, decim_underflow, mag_above_high,
                       mag_below_low, pos_above_high, pos_below_low, hall_current_bad,
                       gp_adc_error, supply_under, supply_over, analog_v_bad,
                       digital_v_bad};

  // Synchroniser over all fault levels.
  // Critical faults ride on top of the bundle so that both groups
  // see the same filter and the same latency.
  fault_sync #(
    .WIDTH (NFLT + CRIT_WIDTH)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .raw     ({crit_fault, raw_bundle}),
    .clean   ({crit_sync, sync_bundle})
  );

  // Writes reach no storage; this only keeps the strobe and data read
  assign wr_unused = wr_en & (|wr_data);

  // Named synchronised lines, one per fault class.
  // Only these names are used below, never raw inputs,
  // so no status bit can see a half-settled level.
  wire       s_dsp   = sync_bundle[B_DSP];      // Self-check failed
  wire       s_nvm   = sync_bundle[B_NVM];      // Parameter checksum failed
  wire       s_mem   = sync_bundle[B_MEM];      // Memory checksum failed
  wire       s_trng  = sync_bundle[B_TRNG];     // Temperature out of range
  wire       s_tred  = sync_bundle[B_TRED];     // Redundant sensor implausible
  wire       s_hsup  = sync_bundle[B_HSUP];     // Hall supply high
  wire       s_otmp  = sync_bundle[B_OTMP];     // Overtemperature
  wire [2:0] s_adc   = sync_bundle[B_ADC_HI:B_ADC_LO]; // Stuck converters
  wire       s_dof   = sync_bundle[B_DOF];      // Filter overflow
  wire       s_duf   = sync_bundle[B_DUF];      // Filter underflow
  wire       s_mhi   = sync_bundle[B_MHI];      // Field high
  wire       s_mlo   = sync_bundle[B_MLO];      // Field low
  wire       s_phi   = sync_bundle[B_PHI];      // Position high
  wire       s_plo   = sync_bundle[B_PLO];      // Position low
  wire       s_hcur  = sync_bundle[B_HCUR];     // Hall current bad
  wire       s_gpadc = sync_bundle[B_GPADC];    // General converter error
  wire       s_uv    = sync_bundle[B_UV];       // Undervoltage
  wire       s_ov    = sync_bundle[B_OV];       // Overvoltage
  wire       s_av    = sync_bundle[B_AV];       // Analog voltage bad
  wire       s_dv    = sync_bundle[B_DV];       // Digital voltage bad

  // Build next status words from current fault levels.
  // Both words start from all zeros, so reserved positions and the
  // low byte of the supply word can never carry a stray one.
  // Bits follow the fault levels; they are not sticky, so a fault
  // that clears is gone from the word one register stage later.
  // The general converter error drives two positions at once;
  // a reader may trust either of them.
  // Build next status words from current fault levels
  always @* begin
    next_processing = `FAULT_WORD_RESET;
    next_supply     = `FAULT_WORD_RESET;
    next_processing[`PF_DSP_SELFCHECK] = s_dsp;
    next_processing[`PF_NVM_CHECKSUM]  = s_nvm;
    next_processing[`PF_MEM_CHECKSUM]  = s_mem;
    next_processing[`PF_TEMP_RANGE]    = s_trng;
    next_processing[`PF_TEMP_REDUND]   = s_tred;
    next_processing[`PF_OVERTEMP]      = s_otmp;
    next_processing[`PF_HALL_SUPPLY]   = s_hsup;
    next_processing[`PF_HALL_CURRENT]  = s_hcur;
    next_processing[`PF_ADC_STUCK]     = |s_adc;
    next_processing[`PF_DECIM_FLOW]    = s_dof | s_duf;
    next_processing[`PF_MAG_HIGH]      = s_mhi;
    next_processing[`PF_MAG_LOW]       = s_mlo;
    next_processing[`PF_POS_HIGH]      = s_phi;
    next_processing[`PF_POS_LOW]       = s_plo;
    next_supply[`SF_GP_ADC_A]          = s_gpadc;
    next_supply[`SF_GP_ADC_B]          = s_gpadc;
    next_supply[`SF_UNDERVOLT]         = s_uv;
    next_supply[`SF_OVERVOLT]          = s_ov;
    next_supply[`SF_ANALOG_V]          = s_av;
    next_supply[`SF_DIGITAL_V]         = s_dv;
  end

  // The status words are registered so that a read in any cycle
  // returns a whole, consistent word, never one half-updated.
  // Self-tests run during start-up and in operation alike, so the
  // words simply track the checks from the first cycle after reset.
  // Status words follow the checks continuously
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      processing_fault_status <= `FAULT_WORD_RESET;
      supply_fault_status     <= `FAULT_WORD_RESET;
    end else begin
      processing_fault_status <= next_processing;
      supply_fault_status     <= next_supply;
    end
  end

  // Summary flags for the output framer.
  // fault_present is any bit of either word; output_suppress covers
  // the faults after which the measured value cannot be trusted.
  // fault_present is registered from the same next values as the words and output_suppress from the same synchronised lines,
  // so they rise and fall in the same cycle as the status bits.
  // Fault flags toward output framer
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fault_present   <= 1'b0;
      output_suppress <= 1'b0;
    end else begin
      fault_present   <= |next_processing | |next_supply;
      output_suppress <= s_dsp | s_nvm | s_mem | s_otmp | |s_adc;
    end
  end

  // The low byte of the supply word is never stored: those faults
  // reset the device at once, so no read could ever show them.
  // Instead any critical line raises a reset request that stands
  // while the fault stands and for a short tail after it, long
  // enough for a slow reset generator to catch it.
  // A new fault during the tail reloads the counter.
  // Critical faults stretch into a reset request
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reset_count      <= 4'h0;
      device_reset_req <= 1'b0;
    end else if (|crit_sync) begin
      reset_count      <= `RESET_PULSE_CYCLES;
      device_reset_req <= 1'b1;
    end else if (reset_count != 4'h0) begin
      reset_count      <= reset_count - 4'h1;
      device_reset_req <= (reset_count != 4'h1);
    end else begin
      device_reset_req <= 1'b0;
    end
  end

  // Read port of the programming interface.
  // A strobe taken at one edge is answered at the next edge, with
  // rd_valid standing one cycle and rd_data holding until the next
  // read. Reads may follow back to back. Both words are read-only:
  // nothing here looks at the write strobe. An index that names no
  // word answers with zero rather than leaving old data standing.
  // Read port; writes ignored, unmapped index reads zero
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        case (rd_index)
          `REG_PROCESSING_FAULT: begin
            rd_data <= processing_fault_status;
          end
          `REG_SUPPLY_FAULT: begin
            rd_data <= {supply_fault_status[15:8], 8'h00};
          end
          default: begin
            rd_data <= 16'h0000;
          end
        endcase
      end
    end
  end

endmodule

/* verif/diag_status_monitor.sv */
// Checker for the diagnosis status bank read port and fault outputs.
// Assumes binding to safety_diagnosis_status_bank by the bind below.
`timescale 1ns/1ps
module diag_status_monitor #(
  parameter CRIT_WIDTH = 8                // Critical fault lines
) (
  input wire                  clk_sys,     // System clock
  input wire                  reset_n,     // Asynchronous active-low reset
  input wire                  rd_en,       // Read strobe
  input wire [3:0]            rd_index,    // Register index
  input wire [15:0]           rd_data,     // Read data
  input wire                  rd_valid,    // Read answer strobe
  input wire                  dsp_selfcheck_fail,
  input wire [CRIT_WIDTH-1:0] crit_fault,  // Faults that reset the device
  input wire                  output_suppress,
  input wire                  device_reset_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Read answer comes exactly one cycle after the strobe
  chk_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read strobe not answered");
  chk_no_spurious: assert property (!rd_en |=> !rd_valid)
    else $error("answer without read strobe");
  chk_supply_lowbyte: assert property (rd_valid && $past(rd_index) == 4'h1 |-> rd_data[7:0] == 8'h00)
    else $error("supply word low byte not zero");
  chk_supply_reserved: assert property (rd_valid && $past(rd_index) == 4'h1 |-> !rd_data[15] && !rd_data[13])
    else $error("supply word reserved bit set");
  chk_gp_pair: assert property (rd_valid && $past(rd_index) == 4'h1 |-> rd_data[14] == rd_data[12])
    else $error("converter error bits disagree");
  chk_proc_reserved: assert property (rd_valid && $past(rd_index) == 4'h0 |-> !rd_data[8] && !rd_data[0])
    else $error("processing word reserved bit set");
  chk_unmapped_zero: assert property (rd_valid && $past(rd_index) > 4'h1 |-> rd_data == 16'h0000)
    else $error("unmapped index read not zero");
  chk_data_hold: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data changed without answer");
  chk_crit_reset: assert property ($rose(crit_fault != 0) |-> ##[1:8] device_reset_req)
    else $error("critical fault gave no reset request");
  chk_dsp_suppress: assert property (dsp_selfcheck_fail [*8] |-> output_suppress)
    else $error("output not suppressed on self-check fault");
  // Main scenarios reached
  cover property (rd_valid && $past(rd_index) == 4'h1 && rd_data != 16'h0000);
  cover property (device_reset_req);
  cover property (output_suppress);
endmodule

bind safety_diagnosis_status_bank diag_status_monitor #(.CRIT_WIDTH(CRIT_WIDTH)) i_diag_status_monitor (
  .clk_sys(clk_sys), .reset_n(reset_n), .rd_en(rd_en), .rd_index(rd_index), .rd_data(rd_data),
  .rd_valid(rd_valid), .dsp_selfcheck_fail(dsp_selfcheck_fail), .crit_fault(crit_fault),
  .output_suppress(output_suppress), .device_reset_req(device_reset_req));

/* verif/diag_reader.sv */
// External tool model reading the diagnosis words.
// Assumes the bank answers one cycle after the strobe is taken.
`timescale 1ns/1ps
module diag_reader (
  input  wire        clk_sys,   // System clock
  input  wire        rd_valid,  // Answer strobe
  input  wire [15:0] rd_data,   // Answer data
  output reg         rd_en,     // Read strobe
  output reg  [3:0]  rd_index,  // Register index
  output reg         wr_en,     // Write strobe
  output reg  [15:0] wr_data    // Write data
);
  // Idle levels at time zero
  initial begin
    rd_en = 1'b0;
    rd_index = 4'hA;
    wr_en = 1'b0;
    wr_data = 16'h5A5A;
  end
  // One read; low byte of the supply word is not relied upon by the tool
  task read_word(input [3:0] idx, output [15:0] val, output ok);
    begin
      @(posedge clk_sys);
      rd_en    <= 1'b1;
      rd_index <= idx;
      @(posedge clk_sys);
      rd_en    <= 1'b0;
      rd_index <= ~idx;
      @(negedge clk_sys);
      ok  = rd_valid;
      val = rd_data;
    end
  endtask
  // One write pulse, data scrambled after release
  task write_word(input [3:0] idx, input [15:0] val);
    begin
      @(posedge clk_sys);
      wr_en    <= 1'b1;
      rd_index <= idx;
      wr_data  <= val;
      @(posedge clk_sys);
      wr_en    <= 1'b0;
      wr_data  <= ~val;
    end
  endtask
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the diagnosis status bank.
// Assumes the reader model and the bound checker.
`timescale 1ns/1ps
module tb_top;
  reg         clk_sys;     // System clock
  reg         reset_n;     // Reset, active low
  reg  [21:0] flt;         // Fault levels, one per input line
  reg  [7:0]  crit_fault;  // Critical faults
  wire        rd_en, wr_en, rd_valid, fault_present, output_suppress, device_reset_req;
  wire [3:0]  rd_index;
  wire [15:0] wr_data, rd_data;
  integer     error_cnt, comparisons, i, k;
  reg  [15:0] got;
  reg         ok;
  // Rows: fault levels, processing word, supply word
  reg  [55:0] rows [0:23] = '{56'h00000180000000, 56'h00000240000000, 56'h00000420000000,
    56'h00000810000000, 56'h00001008000000, 56'h00002004000000, 56'h00004002000000, 56'h00008000800000,
    56'h00010000800000, 56'h00020000800000, 56'h00040000400000, 56'h00080000400000, 56'h00100000200000,
    56'h00200000100000, 56'h00400000080000, 56'h00800000040000, 56'h01000000020000, 56'h02000000005000,
    56'h04000000000800, 56'h08000000000400, 56'h10000000000200, 56'h20000000000100, 56'h3FFFFFFEFE5F00,
    56'h00000000000000};
  safety_diagnosis_status_bank i_safety_diagnosis_status_bank (.clk_sys(clk_sys), .reset_n(reset_n),
    .dsp_selfcheck_fail(flt[0]), .nvm_checksum_fail(flt[1]), .mem_checksum_fail(flt[2]),
    .temp_out_of_range(flt[3]), .temp_redund_fail(flt[4]), .hall_supply_high(flt[5]), .overtemp_hw(flt[6]),
    .adc_stuck(flt[9:7]), .decim_overflow(flt[10]), .decim_underflow(flt[11]), .mag_above_high(flt[12]),
    .mag_below_low(flt[13]), .pos_above_high(flt[14]), .pos_below_low(flt[15]), .hall_current_bad(flt[16]),
    .gp_adc_error(flt[17]), .supply_under(flt[18]), .supply_over(flt[19]), .analog_v_bad(flt[20]),
    .digital_v_bad(flt[21]), .crit_fault(crit_fault), .rd_en(rd_en), .wr_en(wr_en), .rd_index(rd_index),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .fault_present(fault_present),
    .output_suppress(output_suppress), .device_reset_req(device_reset_req));
  diag_reader i_diag_reader (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data), .rd_en(rd_en),
    .rd_index(rd_index), .wr_en(wr_en), .wr_data(wr_data));
  // Clock generator, 20 ns period
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Compares one value and counts it
  task check_val(input [8*16-1:0] name, input [15:0] exp, input [15:0] seen);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // Reads one word and checks answer strobe and data
  task rd_chk(input [3:0] idx, input [15:0] exp);
    begin
      i_diag_reader.read_word(idx, got, ok);
      check_val("rd_valid", 16'h0001, {15'h0000, ok});
      check_val("rd_data", exp, got);
    end
  endtask
  // Prints counts and verdict, ends the run
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    close_out;
  end
  // Main sequence
  initial begin
    error_cnt = 0;
    comparisons = 0;
    reset_n = 1'b0;
    flt = 22'h000000;
    crit_fault = 8'h00;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    check_val("flags", 16'h0000, {13'h0000, fault_present, output_suppress, device_reset_req});
    $display("reset test done");
    // Table rows: one fault at a time, then all, then none
    for (i = 0; i < 24; i = i + 1) begin
      @(posedge clk_sys);
      flt <= rows[i][53:32];
      repeat (8) @(posedge clk_sys);
      rd_chk(4'h0, rows[i][31:16]);
      rd_chk(4'h1, rows[i][15:0]);
      check_val("fault_present", {15'h0000, |rows[i][53:32]}, {15'h0000, fault_present});
      check_val("suppress", {15'h0000, |(rows[i][53:32] & 22'h0003C7)}, {15'h0000, output_suppress});
      $display("row %0d done", i);
    end
    // Writes are ignored, unmapped indices read zero
    i_diag_reader.write_word(4'h1, 16'hFFFF);
    rd_chk(4'h1, 16'h0000);
    rd_chk(4'h2, 16'h0000);
    rd_chk(4'hF, 16'h0000);
    $display("write and unmapped test done");
    // Each critical fault line requests a reset
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge clk_sys);
      crit_fault <= 8'h01 << i;
      for (k = 0; k < 8 && device_reset_req !== 1'b1; k = k + 1)
        @(negedge clk_sys);
      check_val("reset_req", 16'h0001, {15'h0000, device_reset_req});
      rd_chk(4'h1, 16'h0000);
      @(posedge clk_sys);
      crit_fault <= 8'h00;
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      check_val("reset_req", 16'h0000, {15'h0000, device_reset_req});
    end
    $display("critical fault test done");
    // Reset in mid-run while every ordinary fault stands, no critical fault
    @(posedge clk_sys);
    flt <= 22'h3FFFFF;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    check_val("flags", 16'h0000, {13'h0000, fault_present, output_suppress, device_reset_req});
    repeat (8) @(posedge clk_sys);
    rd_chk(4'h0, 16'hFEFE);
    @(posedge clk_sys);
    flt <= 22'h000000;
    $display("mid-run reset test done");
    close_out;
  end
endmodule
